// File: mvf_pkg.sv
package mvf_pkg;
    // opcode patterns
    localparam logic [7:0] OP_GEN_MASK = 8'he8;
    localparam logic [7:0] OP_GEN_VAL  = 8'h80;
    localparam logic [7:0] OP_IMM8     = 8'h06;
    localparam logic [7:0] OP_IMM16    = 8'h07;
    localparam logic [7:0] OP_SBI_MASK = 8'hf8;
    localparam logic [7:0] OP_SBI_VAL  = 8'h50;
    localparam logic [7:0] OP_FRM_MASK = 8'he0;
    localparam logic [7:0] OP_FRM_VAL  = 8'h80;
    // field positions and frame pointer register
    localparam int DIR_BIT  = 4;
    localparam int SIZE_BIT = 3;
    localparam logic [2:0] FP_REG = 3'h6;
    // values after reset
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic        RST_BIT  = 1'b0;
    localparam logic        RST_RDY  = 1'b1;

    typedef enum logic [1:0] {EA_REG, EA_MEM, EA_IMM8, EA_IMM16} mvf_ea_mode_t;

    typedef struct packed {
        logic         has_ea;
        mvf_ea_mode_t ea_mode;
        logic         ea_word;
        logic [2:0]   ea_reg;
        logic [15:0]  ea_addr;
        logic [15:0]  ea_imm;
        logic [7:0]   op;
        logic [7:0]   ext0;
        logic [7:0]   ext1;
    } mvf_ins_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mvf_mem_t;

    function automatic logic [15:0] mvf_sext8(input logic [7:0] b);
        return {{8{b[7]}}, b};
    endfunction

    // {n, z} of a value at its size
    function automatic logic [1:0] mvf_nz(input logic [15:0] v, input logic w);
        return w ? {v[15], v == 16'h0000} : {v[7], v[7:0] == 8'h00};
    endfunction

    function automatic logic mvf_is_sbi(input mvf_ins_t i);
        return !i.has_ea && ((i.op & OP_SBI_MASK) == OP_SBI_VAL);
    endfunction

    function automatic logic mvf_is_gen(input mvf_ins_t i);
        return i.has_ea && ((i.op & OP_GEN_MASK) == OP_GEN_VAL);
    endfunction
endpackage

// File: mvf_move_unit.sv
`timescale 1ns/1ps
module mvf_move_unit
    import mvf_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // instruction from fetch path
    input  wire logic        ins_valid,
    input  wire mvf_ins_t    ins,
    output logic             ins_ready,
    // memory access unit
    output mvf_mem_t         mem,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata,
    // carry written by other instructions
    input  wire logic        c_wr,
    input  wire logic        c_in,
    // flags
    output logic             flag_n,
    output logic             flag_z,
    output logic             flag_v,
    output logic             flag_c,
    // completion
    output logic             done,
    output logic             illegal,
    output logic [15:0]      mv_data,
    output logic             mv_word,
    // register observation
    input  wire logic [2:0]  dbg_sel,
    output logic [15:0]      dbg_data
);
    typedef enum logic [2:0] {S_IDLE, S_EXEC, S_RD, S_WR, S_WB} mvf_state_t;

    mvf_state_t  st;
    mvf_state_t  next_st;
    mvf_ins_t    q;
    logic [15:0] regs [8];
    logic [15:0] val;
    logic        word;
    logic [15:0] next_val;
    logic [15:0] next_addr;
    logic        next_word;
    logic        next_we;
    logic        next_bad;

    // decode of captured instruction; in_sbi decodes the offered one
    wire         acc      = ins_valid && ins_ready;
    wire         q_gen    = mvf_is_gen(q);
    wire         q_store  = q.op[DIR_BIT];
    wire         q_gimm   = q.has_ea && (q.op == OP_IMM8 || q.op == OP_IMM16);
    wire         q_frm    = !q.has_ea && ((q.op & OP_FRM_MASK) == OP_FRM_VAL);
    wire         q_mem    = q.ea_mode == EA_MEM;
    wire [2:0]   q_rn     = q.op[2:0];
    wire [15:0]  rn_val   = regs[q_rn];
    wire [15:0]  ea_val   = regs[q.ea_reg];
    wire [15:0]  fp_addr  = regs[FP_REG] + mvf_sext8(q.ext0);
    wire [15:0]  gimm_val = (q.op == OP_IMM16) ? {q.ext0, q.ext1} : mvf_sext8(q.ext0);
    wire [15:0]  ea_src   = (q.ea_mode == EA_REG)  ? ea_val :
                            (q.ea_mode == EA_IMM8) ? mvf_sext8(q.ea_imm[7:0]) : q.ea_imm;
    wire         wr_end   = (st == S_WR) && mem_ack;
    wire         fin      = (st == S_WB) || wr_end;
    wire [1:0]   nz       = mvf_nz(val, word);
    wire         in_sbi   = mvf_is_sbi(ins);

    // execution step
    always_comb begin
        next_st   = st;
        next_val  = val;
        next_addr = mem.addr;
        next_word = word;
        next_we   = mem.we;
        next_bad  = 1'b0;
        case (st)
            S_IDLE: begin
                if (acc) begin
                    next_st   = in_sbi ? S_WB : S_EXEC;
                    next_val  = {8'h00, ins.ext0};
                    next_word = 1'b0;
                end
            end
            S_EXEC: begin
                next_word = q_frm ? q.op[SIZE_BIT] : q.ea_word;
                next_addr = q_frm ? fp_addr : q.ea_addr;
                if (q_gen && !q_store) begin
                    next_st  = q_mem ? S_RD : S_WB;
                    next_val = ea_src;
                    next_we  = 1'b0;
                end else if (q_gen) begin
                    next_st  = q_mem ? S_WR : S_IDLE;
                    next_bad = !q_mem;
                    next_val = rn_val;
                    next_we  = 1'b1;
                end else if (q_gimm) begin
                    next_st  = q_mem ? S_WR : S_IDLE;
                    next_bad = !q_mem;
                    next_val = gimm_val;
                    next_we  = 1'b1;
                end else if (q_frm) begin
                    next_st  = q_store ? S_WR : S_RD;
                    next_val = rn_val;
                    next_we  = q_store;
                end else begin
                    next_st  = S_IDLE;
                    next_bad = 1'b1;
                end
            end
            S_RD: begin
                if (mem_ack) begin
                    next_st  = S_WB;
                    next_val = word ? mem_rdata : {8'h00, mem_rdata[7:0]};
                end
            end
            S_WR: begin
                if (mem_ack) begin
                    next_st = S_IDLE;
                end
            end
            S_WB: begin
                next_st = S_IDLE;
            end
            default: begin
                next_st = S_IDLE;
            end
        endcase
    end

    // state and datapath registers
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st        <= S_IDLE;
            q         <= '0;
            val       <= RST_WORD;
            word      <= RST_BIT;
            ins_ready <= RST_RDY;
            illegal   <= RST_BIT;
        end else begin
            st        <= next_st;
            val       <= next_val;
            word      <= next_word;
            ins_ready <= next_st == S_IDLE;
            illegal   <= next_bad;
            if (acc) begin
                q <= ins;
            end
        end
    end

    // memory request held until acknowledged
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            mem <= '0;
        end else begin
            mem.addr  <= next_addr;
            mem.we    <= next_we;
            mem.word  <= next_word;
            mem.wdata <= next_val;
            if (st == S_EXEC) begin
                mem.req <= next_st == S_RD || next_st == S_WR;
            end else if (mem_ack) begin
                mem.req <= 1'b0;
            end
        end
    end

    // register file
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            for (int i = 0; i < 8; i++) begin
                regs[i] <= RST_WORD;
            end
            dbg_data <= RST_WORD;
        end else begin
            dbg_data <= regs[dbg_sel];
            if (st == S_WB) begin
                if (word) begin
                    regs[q_rn] <= val;
                end else begin
                    regs[q_rn][7:0] <= val[7:0];
                end
            end
        end
    end

    // flags and completion
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            flag_n  <= RST_BIT;
            flag_z  <= RST_BIT;
            flag_v  <= RST_BIT;
            flag_c  <= RST_BIT;
            done    <= RST_BIT;
            mv_data <= RST_WORD;
            mv_word <= RST_BIT;
        end else begin
            done <= fin;
            if (fin) begin
                flag_n  <= nz[1];
                flag_z  <= nz[0];
                flag_v  <= 1'b0;
                mv_data <= val;
                mv_word <= word;
            end
            if (c_wr) begin
                flag_c <= c_in;
            end
        end
    end

    property p_nflag;
        @(posedge core_clk) disable iff (!rst_b)
        done |-> flag_n == (mv_word ? mv_data[15] : mv_data[7]);
    endproperty
    a_nflag: assert property (p_nflag) else $error("negative flag wrong");

    property p_zflag;
        @(posedge core_clk) disable iff (!rst_b)
        done |-> flag_z == (mv_word ? mv_data == 16'h0000 : mv_data[7:0] == 8'h00);
    endproperty
    a_zflag: assert property (p_zflag) else $error("zero flag wrong");

    property p_vflag;
        @(posedge core_clk) disable iff (!rst_b)
        done |-> !flag_v;
    endproperty
    a_vflag: assert property (p_vflag) else $error("overflow not cleared");

    property p_cflag;
        @(posedge core_clk) disable iff (!rst_b)
        (done && !$past(c_wr)) |-> flag_c == $past(flag_c);
    endproperty
    a_cflag: assert property (p_cflag) else $error("carry changed by move");

    property p_sbi_time;
        @(posedge core_clk) disable iff (!rst_b)
        (acc && in_sbi) |=> ##1 done && mv_data[7:0] == $past(ins.ext0, 2);
    endproperty
    a_sbi_time: assert property (p_sbi_time) else $error("short immediate late");

    property p_gload_time;
        @(posedge core_clk) disable iff (!rst_b)
        (acc && mvf_is_gen(ins) && !ins.op[DIR_BIT] && ins.ea_mode != EA_MEM)
            |=> !done ##1 !done ##1 done;
    endproperty
    a_gload_time: assert property (p_gload_time) else $error("general load timing");

    property p_store_ea;
        @(posedge core_clk) disable iff (!rst_b)
        (acc && mvf_is_gen(ins) && ins.op[DIR_BIT] && ins.ea_mode != EA_MEM)
            |=> ##1 illegal && !mem.req;
    endproperty
    a_store_ea: assert property (p_store_ea) else $error("store to non-memory taken");

    property p_sext;
        @(posedge core_clk) disable iff (!rst_b)
        (st == S_EXEC && q_gimm && q_mem && q.op == OP_IMM8 && q.ea_word)
            |=> mem.req && mem.we && mem.wdata == mvf_sext8(q.ext0);
    endproperty
    a_sext: assert property (p_sext) else $error("immediate not extended");

    property p_frame_addr;
        @(posedge core_clk) disable iff (!rst_b)
        (st == S_EXEC && q_frm)
            |=> mem.req && mem.addr == $past(fp_addr) && mem.we == q.op[DIR_BIT];
    endproperty
    a_frame_addr: assert property (p_frame_addr) else $error("frame address wrong");

    property p_store_data;
        @(posedge core_clk) disable iff (!rst_b)
        (st == S_EXEC && q_gen && q_store && q_mem)
            |=> mem.we && mem.wdata == $past(rn_val) && mem.addr == q.ea_addr;
    endproperty
    a_store_data: assert property (p_store_data) else $error("store data wrong");

    property p_illegal_quiet;
        @(posedge core_clk) disable iff (!rst_b)
        illegal |-> !done && !mem.req && flag_z == $past(flag_z) && flag_n == $past(flag_n);
    endproperty
    a_illegal_quiet: assert property (p_illegal_quiet) else $error("refused move acted");

    property p_load_dir;
        @(posedge core_clk) disable iff (!rst_b)
        (st == S_EXEC && q_gen && !q_store)
            |=> !mem.we && mem.req == q_mem;
    endproperty
    a_load_dir: assert property (p_load_dir) else $error("load direction wrong");
endmodule

// File: mvf_mem_model.sv
`timescale 1ns/1ps
// memory access unit with programmable acknowledge delay
module mvf_mem_model
    import mvf_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // request side
    input  wire mvf_mem_t    mem,
    input  wire logic [3:0]  ack_dly,
    output logic             mem_ack,
    output logic [15:0]      mem_rdata
);
    logic [7:0]  m [int];
    logic [3:0]  cnt;
    logic [15:0] rd;
    // read data only beside the acknowledge, inverted otherwise
    assign mem_rdata = mem_ack ? rd : ~rd;
    always @(posedge core_clk) begin
        if (!rst_b) begin
            mem_ack <= 1'b0;
            cnt <= 4'h0;
            rd <= 16'h0000;
        end else if (mem.req && !mem_ack) begin
            if (cnt == ack_dly) begin
                mem_ack <= 1'b1;
                cnt <= 4'h0;
                if (mem.we && mem.word) begin
                    m[mem.addr] = mem.wdata[15:8];
                    m[mem.addr + 1] = mem.wdata[7:0];
                end else if (mem.we) begin
                    m[mem.addr] = mem.wdata[7:0];
                end else begin
                    rd <= mem.word ? {m[mem.addr], m[mem.addr + 1]} : {8'h00, m[mem.addr]};
                end
            end else begin
                cnt <= cnt + 4'h1;
            end
        end else begin
            mem_ack <= 1'b0;
        end
    end
endmodule

// File: move_instruction_family_bench.sv
`timescale 1ns/1ps
module move_instruction_family_bench
    import mvf_pkg::*;
;
    logic        core_clk, rst_b, ins_valid, ins_ready, mem_ack, c_wr, c_in, ill;
    logic        flag_n, flag_z, flag_v, flag_c, done, illegal, mv_word;
    logic [15:0] mem_rdata, mv_data, dbg_data;
    logic [2:0]  dbg_sel;
    logic [3:0]  ack_dly;
    mvf_ins_t    ins;
    mvf_mem_t    mem;
    int          num_errors, tests_run, lat;

    mvf_move_unit mvf_move_unit_i (.core_clk(core_clk), .rst_b(rst_b), .ins_valid(ins_valid),
        .ins(ins), .ins_ready(ins_ready), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .c_wr(c_wr), .c_in(c_in), .flag_n(flag_n), .flag_z(flag_z), .flag_v(flag_v),
        .flag_c(flag_c), .done(done), .illegal(illegal), .mv_data(mv_data),
        .mv_word(mv_word), .dbg_sel(dbg_sel), .dbg_data(dbg_data));
    mvf_mem_model mvf_mem_model_i (.core_clk(core_clk), .rst_b(rst_b), .mem(mem),
        .ack_dly(ack_dly), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // short forms: ea_imm carries {e0, e1}
    function automatic mvf_ins_t mk(logic h, mvf_ea_mode_t md, logic w, logic [15:0] a,
                                    logic [7:0] op, logic [7:0] e0, logic [7:0] e1);
        return '{h, md, w, 3'h3, a, {e0, e1}, op, e0, e1};
    endfunction

    function automatic logic [15:0] mw(int a);
        return {mvf_mem_model_i.m[a], mvf_mem_model_i.m[a + 1]};
    endfunction

    // offer one instruction, wait for done or illegal
    task automatic run(input mvf_ins_t i);
        int k;
        ins_valid <= 1'b1;
        ins <= i;
        k = 0;
        do @(posedge core_clk); while (ins_ready !== 1'b1 && ++k < 50);
        ins_valid <= 1'b0;
        lat = 0;
        do begin
            @(posedge core_clk);
            lat++;
        end while (done !== 1'b1 && illegal !== 1'b1 && lat < 50);
        ill = illegal;
        check("finish", 16'(k < 50 && lat < 50), 16'h0001);
    endtask

    task automatic flags(input logic [15:0] v, input logic n, input logic z);
        check("mv_data", mv_data, v);
        check("nzv", {13'h0, flag_n, flag_z, flag_v}, {13'h0, n, z, 1'b0});
    endtask

    task automatic rd_reg(input logic [2:0] r, input logic [15:0] exp);
        dbg_sel <= r;
        repeat (3) @(posedge core_clk);
        check("reg", dbg_data, exp);
    endtask

    task automatic t_short();
        int l8;
        run(mk(1'b0, EA_REG, 1'b0, '0, OP_SBI_VAL | 8'h03, 8'h80, '0));
        l8 = lat;
        flags(16'h0080, 1'b1, 1'b0);
        rd_reg(3'h3, 16'h0080);
        run(mk(1'b0, EA_REG, 1'b0, '0, OP_SBI_VAL | 8'h03, 8'h00, '0));
        flags(16'h0000, 1'b0, 1'b1);
        run(mk(1'b1, EA_IMM8, 1'b0, '0, OP_GEN_VAL | 8'h03, '0, 8'h7f));
        flags(16'h007f, 1'b0, 1'b0);
        check("latency", 16'(lat - l8), 16'h0001);
    endtask

    task automatic t_load();
        mvf_ea_mode_t md [4] = '{EA_REG, EA_MEM, EA_IMM8, EA_IMM16};
        logic [15:0]  ex [4] = '{16'h007f, 16'h8001, 16'hff80, 16'h1280};
        mvf_mem_model_i.m[16'h0200] = 8'h80;
        mvf_mem_model_i.m[16'h0201] = 8'h01;
        ack_dly <= 4'h3;
        for (int k = 0; k < 4; k++) begin
            run(mk(1'b1, md[k], 1'b1, 16'h0200, OP_GEN_VAL | 8'h01, 8'h12, 8'h80));
            flags(ex[k], ex[k][15], 1'b0);
            check("mv_word", {15'h0, mv_word}, 16'h0001);
            rd_reg(3'h1, ex[k]);
        end
    endtask

    task automatic t_store();
        run(mk(1'b1, EA_MEM, 1'b1, 16'h0300, OP_GEN_VAL | 8'h11, '0, '0));
        check("mem", mw(16'h0300), 16'h1280);
        run(mk(1'b1, EA_MEM, 1'b1, 16'h0310, OP_IMM8, 8'h80, '0));
        check("mem", mw(16'h0310), 16'hff80);
        run(mk(1'b1, EA_MEM, 1'b1, 16'h0320, OP_IMM16, 8'hab, 8'hcd));
        check("mem", mw(16'h0320), 16'habcd);
        run(mk(1'b1, EA_REG, 1'b1, '0, OP_GEN_VAL | 8'h11, '0, '0));
        check("illegal", {15'h0, ill}, 16'h0001);
        run(mk(1'b1, EA_IMM8, 1'b1, '0, OP_IMM8, 8'h00, '0));
        check("illegal", {15'h0, ill}, 16'h0001);
        flags(16'habcd, 1'b1, 1'b0);
    endtask

    task automatic t_frame();
        ack_dly <= 4'h0;
        run(mk(1'b0, EA_REG, 1'b0, '0, OP_SBI_VAL | {5'h0, FP_REG}, 8'h40, '0));
        run(mk(1'b0, EA_REG, 1'b0, '0, OP_FRM_VAL | 8'h11, 8'hfe, '0));
        check("mem", {8'h00, mvf_mem_model_i.m[16'h003e]}, 16'h0080);
        flags(16'h1280, 1'b1, 1'b0);
        check("mv_word", {15'h0, mv_word}, 16'h0000);
        mvf_mem_model_i.m[16'h0042] = 8'h01;
        mvf_mem_model_i.m[16'h0043] = 8'h00;
        run(mk(1'b0, EA_REG, 1'b0, '0, OP_FRM_VAL | 8'h0d, 8'h02, '0));
        flags(16'h0100, 1'b0, 1'b0);
        rd_reg(3'h5, 16'h0100);
    endtask

    task automatic t_carry();
        c_wr <= 1'b1;
        c_in <= 1'b1;
        @(posedge core_clk);
        c_wr <= 1'b0;
        run(mk(1'b0, EA_REG, 1'b0, '0, OP_SBI_VAL, 8'h00, '0));
        check("carry", {15'h0, flag_c}, 16'h0001);
    endtask

    initial begin
        rst_b = 1'b0;
        ins_valid = 1'b0;
        ins = '0;
        c_wr = 1'b0;
        c_in = 1'b0;
        dbg_sel = '0;
        ack_dly = '0;
        num_errors = 0;
        tests_run = 0;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        t_short();
        t_load();
        t_store();
        t_frame();
        t_carry();
        test_done();
    end

    initial begin
        #100000;
        num_errors++;
        test_done();
    end
endmodule
